// [design/eirq_top.sv]
// Summary of operation
// - first pin mode 0x: request is the pin level, active low.
// - first pin mode 10: falling edge sets a latch held until cleared.
// - first pin mode 11: rising edge sets the latch, cleared likewise.
// - writing one to edge bit 2 clears the first pin latch.
// - writing one to bit 3 clears second latch; zeros do nothing.
// - reading bits 3 and 2 returns second and first pin levels.
// - bit 0 routes shared pin as carrier detect or clock; detect always fed.
// - edge polarity may change any time and applies to later edges.
// - requests are sampled at the cpu sample point of each instruction.
// - an inhibiting instruction blocks acceptance right after it.
// - accept only with active request and the global flag; pin requests also need their enable, on-chip ones have none.
// - push return address, then read two bytes; first pin code 00000, 00001.
// - second pin reads use 00010 then 00011 on low address lines.
// - first byte is low, second high of the service address.
// - on-chip sources use the same fetch, differing in address lines 4..1.
// - second pin mode field in bits 7..6 behaves like the first.
// - low vector bits are cleared by reset.
`timescale 1ns/1ps
`default_nettype none
`include "eirq_consts.svh"
module eirq_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic ext_request_a,
	input wire logic ext_request_b,
	input wire logic carrier_detect_pin,
	input wire logic global_irq_enable_flag,
	input wire logic sample_point,
	input wire logic accept_inhibit,
	input wire logic instr_done,
	input wire logic onchip_req,
	input wire logic [3:0] onchip_code,
	input wire logic push_ack,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic drive_reduced,
	output logic carrier_detect_out,
	output logic async_clock_out,
	output logic push_req,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	output logic [15:0] isr_addr,
	output logic isr_valid
);
	eirq_pkg::eirq_top_s r;
	eirq_pkg::eirq_top_s n;
	logic lvl_a;
	logic lvl_b;
	logic act_a;
	logic act_b;
	logic busy;
	logic want_a;
	logic want_b;
	logic addr_take;
	logic wr_edge;
	logic rd_edge;
	logic rd_vlow;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		addr_is = (a == ofs);
	endfunction

	// ==========================================================
	// pin capture and vector fetch
	eirq_pin_capture u_cap_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(ext_request_a),
		.mode(r.mode_a),
		.clear(r.clr_a),
		.level(lvl_a),
		.active(act_a)
	);
	eirq_pin_capture u_cap_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(ext_request_b),
		.mode(r.mode_b),
		.clear(r.clr_b),
		.level(lvl_b),
		.active(act_b)
	);
	eirq_vector_seq u_seq (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(r.start),
		.src_code(r.taken_code),
		.vec_page(r.vpage),
		.vec_low(r.vlow),
		.push_ack(push_ack),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.push_req(push_req),
		.mem_rd(mem_rd),
		.mem_addr(mem_addr),
		.isr_addr(isr_addr),
		.isr_valid(isr_valid),
		.busy(busy)
	);

	// ==========================================================
	// decode helpers
	assign addr_take = hsel & htrans[1] & hready;
	assign wr_edge = r.pend & r.pend_write & r.pend_word & addr_is(r.pend_addr, `EIRQ_OFS_EDGE);
	assign rd_edge = r.pend & ~r.pend_write & addr_is(r.pend_addr, `EIRQ_OFS_EDGE);
	assign rd_vlow = r.pend & ~r.pend_write & addr_is(r.pend_addr, `EIRQ_OFS_VLOW);
	// enable bits 1 and 2 of the trap control register gate the pins
	assign want_a = act_a & r.itc_en[0];
	assign want_b = act_b & r.itc_en[1];

	// ==========================================================
	// next state
	always_comb begin
		n = r;
		n.resp = 1'h0;
		n.clr_a = 1'h0;
		n.clr_b = 1'h0;
		n.start = 1'h0;
		// one wait state: read data come from a flop, and a write just
		// before a read is always seen by it
		if (r.pend) begin
			n.pend = 1'h0;
			n.hready_out = 1'h1;
			n.rdata = 32'h0000_0000;
			if (r.pend_write) begin
				if (!r.pend_word) begin
					n.pend = 1'h0;
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_EDGE)) begin
					n.mode_b = hwdata[`EIRQ_B_MODE_HI:`EIRQ_B_MODE_LO];
					n.mode_a = hwdata[`EIRQ_A_MODE_HI:`EIRQ_A_MODE_LO];
					n.clr_b = hwdata[`EIRQ_B_SENSE];
					n.clr_a = hwdata[`EIRQ_A_SENSE];
					n.drive = hwdata[`EIRQ_DRIVE];
					n.route = hwdata[`EIRQ_ROUTE];
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_VLOW)) begin
					n.vlow = hwdata[7:5];
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_ITC)) begin
					n.itc_en = hwdata[2:1];
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_VPAGE)) begin
					n.vpage = hwdata[7:0];
				end
			end else begin
				if (addr_is(r.pend_addr, `EIRQ_OFS_EDGE)) begin
					// sense bits read the pin levels, not the written ones
					n.rdata = {24'h00_0000, r.mode_b, r.mode_a, lvl_b, lvl_a, r.drive, r.route};
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_VLOW)) begin
					n.rdata = {24'h00_0000, r.vlow, 5'h00};
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_ITC)) begin
					n.rdata = {29'h0000_0000, r.itc_en, 1'h0};
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_VPAGE)) begin
					n.rdata = {24'h00_0000, r.vpage};
				end else if (addr_is(r.pend_addr, `EIRQ_OFS_STATUS)) begin
					n.rdata = {16'h0000, r.accept_cnt, r.last_code, busy, r.taken, act_b, act_a};
				end
			end
		end else if (addr_take) begin
			n.pend = 1'h1;
			n.hready_out = 1'h0;
			n.pend_write = hwrite;
			n.pend_word = (hsize == `EIRQ_HSIZE_WORD);
			n.pend_addr = haddr[7:0];
		end

		// shared pin: always feeds carrier detect, clock only while the route bit is clear
		n.sh_sync = {r.sh_sync[1:0], carrier_detect_pin};
		if (r.sh_sync[1] == r.sh_sync[2]) begin
			n.sh_level = r.sh_sync[2];
		end
		n.cd_out = r.sh_level;
		n.clk_out = r.route ? 1'h1 : r.sh_level;

		// instruction end: start the fetch for what was sampled
		if (instr_done && r.taken) begin
			n.start = 1'h1;
			n.taken = 1'h0;
			n.last_code = r.taken_code;
			n.accept_cnt = 8'(r.accept_cnt + 8'h01);
		end
		// sample point of the instruction
		if (sample_point) begin
			n.taken = 1'h0;
			if (!accept_inhibit && global_irq_enable_flag && !busy && !n.start) begin
				if (want_a) begin
					n.taken = 1'h1;
					n.taken_code = `EIRQ_CODE_A;
				end else if (want_b) begin
					n.taken = 1'h1;
					n.taken_code = `EIRQ_CODE_B;
				end else if (onchip_req) begin
					n.taken = 1'h1;
					n.taken_code = onchip_code;
				end
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.hready_out <= 1'h1;
			r.mode_b <= 2'h0;
			r.mode_a <= 2'h0;
			r.drive <= 1'h0;
			r.vlow <= `EIRQ_VLOW_RST;
			r.sh_sync <= 3'h7;
			r.sh_level <= 1'h1;
			r.cd_out <= 1'h1;
			r.clk_out <= 1'h1;
		end else begin
			r <= n;
		end
	end

	assign hreadyout = r.hready_out;
	assign hrdata = r.rdata;
	assign hresp = r.resp;
	assign drive_reduced = r.drive;
	assign carrier_detect_out = r.cd_out;
	assign async_clock_out = r.clk_out;

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence addr_phase_s;
		addr_take && !r.pend;
	endsequence
	bus_wait_a: assert property (addr_phase_s |=> !hreadyout ##1 hreadyout)
		else $error("bus answer not after one wait state");
	drive_sel_a: assert property (wr_edge |=> drive_reduced == $past(hwdata[1]))
		else $error("drive select not taken from write");
	route_clk_a: assert property (r.route |=> async_clock_out)
		else $error("clock output active while routed to carrier detect");
	cd_follow_a: assert property (carrier_detect_out == $past(r.sh_level))
		else $error("carrier detect not fed by shared pin");
	lvl_read_a: assert property (rd_edge |=> hrdata[3:2] == $past({lvl_b, lvl_a}))
		else $error("sense bits do not show pin levels");
	clear_a_a: assert property (wr_edge && hwdata[2] |=> r.clr_a)
		else $error("first latch clear not issued");
	no_clear_a: assert property (wr_edge && !hwdata[3] |=> !r.clr_b)
		else $error("zero write cleared second latch");
	vlow_read_a: assert property (rd_vlow |=> hrdata[7:0] == {$past(r.vlow), 5'h00})
		else $error("low vector read wrong");
	gate_ok_a: assert property ($rose(r.taken) |-> $past(sample_point && global_irq_enable_flag))
		else $error("request taken without global enable");
	inhibit_a: assert property (sample_point && accept_inhibit |=> !r.taken)
		else $error("request taken after inhibiting instruction");
	prio_a_a: assert property (sample_point && !accept_inhibit && global_irq_enable_flag && !busy
		&& !r.taken && want_a |=> r.taken && r.taken_code == `EIRQ_CODE_A)
		else $error("first pin not taken with its code");
	start_a: assert property (r.taken && instr_done && !sample_point |=> r.start && !r.taken)
		else $error("sampled request not started at instruction end");
	reset_mode_a: assert property ($rose(hresetn) |-> r.mode_a == 2'h0 && r.mode_b == 2'h0)
		else $error("pins not level sensitive after reset");
endmodule
`default_nettype wire

// [design/eirq_consts.svh]
`ifndef EIRQ_CONSTS_SVH
`define EIRQ_CONSTS_SVH
// ==========================================================
// register byte offsets (haddr[7:0])
`define EIRQ_OFS_EDGE 8'h00
`define EIRQ_OFS_VLOW 8'h04
`define EIRQ_OFS_ITC 8'h08
`define EIRQ_OFS_VPAGE 8'h0C
`define EIRQ_OFS_STATUS 8'h10
// ==========================================================
// edge control field positions
`define EIRQ_B_MODE_HI 7
`define EIRQ_B_MODE_LO 6
`define EIRQ_A_MODE_HI 5
`define EIRQ_A_MODE_LO 4
`define EIRQ_B_SENSE 3
`define EIRQ_A_SENSE 2
`define EIRQ_DRIVE 1
`define EIRQ_ROUTE 0
// ==========================================================
// reset values and fixed source codes (address lines 4..1)
`define EIRQ_EDGE_RST 8'h00
`define EIRQ_VLOW_RST 3'h0
`define EIRQ_CODE_A 4'h0
`define EIRQ_CODE_B 4'h1
`define EIRQ_HSIZE_WORD 3'h2
`endif

// [design/eirq_pkg.sv]
package eirq_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_RD_LO, SEQ_RD_HI} eirq_seq_e;
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic latch;
		logic active;
	} eirq_cap_s;
	typedef struct packed {
		eirq_seq_e state;
		logic [3:0] code;
		logic [7:0] lo;
		logic push_req;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic [15:0] isr_addr;
		logic isr_valid;
		logic busy;
	} eirq_seq_s;
	typedef struct packed {
		logic resp;
		logic hready_out;
		logic [31:0] rdata;
		logic pend;
		logic pend_write;
		logic pend_word;
		logic [7:0] pend_addr;
		logic [1:0] mode_b;
		logic [1:0] mode_a;
		logic drive;
		logic route;
		logic clr_a;
		logic clr_b;
		logic [2:0] vlow;
		logic [1:0] itc_en;
		logic [7:0] vpage;
		logic [2:0] sh_sync;
		logic sh_level;
		logic cd_out;
		logic clk_out;
		logic taken;
		logic [3:0] taken_code;
		logic start;
		logic [3:0] last_code;
		logic [7:0] accept_cnt;
	} eirq_top_s;
endpackage

// [design/eirq_pin_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module eirq_pin_capture (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin,
	input wire logic [1:0] mode,
	input wire logic clear,
	output logic level,
	output logic active
);
	eirq_pkg::eirq_cap_s r;
	eirq_pkg::eirq_cap_s n;
	logic fall;
	logic rise;
	logic hit;
	always_comb begin
		n = r;
		n.sync = {r.sync[1:0], pin};
		if (r.sync[1] == r.sync[2]) begin
			n.level = r.sync[2];
		end
		fall = r.level & ~n.level;
		rise = ~r.level & n.level;
		// polarity follows the current mode, so it may change at any time
		hit = mode[1] & (mode[0] ? rise : fall);
		// a new edge beats a clear in the same cycle
		n.latch = hit | (r.latch & ~clear);
		n.active = mode[1] ? n.latch : ~r.level;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.sync <= 3'h7;
			r.level <= 1'h1;
		end else begin
			r <= n;
		end
	end
	assign level = r.level;
	assign active = r.active;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	level_mode_a: assert property (!mode[1] |=> active == !$past(r.level))
		else $error("level mode request not low active");
	fall_latch_a: assert property (mode == 2'h2 && fall |=> r.latch)
		else $error("falling edge not latched");
	rise_latch_a: assert property (mode == 2'h3 && rise |=> r.latch)
		else $error("rising edge not latched");
	latch_clear_a: assert property (clear && !hit |=> !r.latch)
		else $error("edge latch not cleared");
endmodule
`default_nettype wire

// [design/eirq_vector_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module eirq_vector_seq (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [3:0] src_code,
	input wire logic [7:0] vec_page,
	input wire logic [2:0] vec_low,
	input wire logic push_ack,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic push_req,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	output logic [15:0] isr_addr,
	output logic isr_valid,
	output logic busy
);
	eirq_pkg::eirq_seq_s r;
	eirq_pkg::eirq_seq_s n;
	always_comb begin
		n = r;
		n.isr_valid = 1'h0;
		case (r.state)
			eirq_pkg::SEQ_IDLE: if (start) begin
				n.code = src_code;
				n.mem_addr = {vec_page, vec_low, src_code, 1'h0};
				n.push_req = 1'h1; // return address goes first
				n.busy = 1'h1;
				n.state = eirq_pkg::SEQ_PUSH;
			end
			eirq_pkg::SEQ_PUSH: if (push_ack) begin
				n.push_req = 1'h0;
				n.mem_rd = 1'h1;
				n.state = eirq_pkg::SEQ_RD_LO;
			end
			eirq_pkg::SEQ_RD_LO: if (mem_ack) begin
				n.lo = mem_rdata;
				n.mem_addr[0] = 1'h1;
				n.state = eirq_pkg::SEQ_RD_HI;
			end
			eirq_pkg::SEQ_RD_HI: if (mem_ack) begin
				n.mem_rd = 1'h0;
				n.isr_addr = {mem_rdata, r.lo};
				n.isr_valid = 1'h1;
				n.busy = 1'h0;
				n.state = eirq_pkg::SEQ_IDLE;
			end
			default: n.state = eirq_pkg::SEQ_IDLE;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
	assign push_req = r.push_req;
	assign mem_rd = r.mem_rd;
	assign mem_addr = r.mem_addr;
	assign isr_addr = r.isr_addr;
	assign isr_valid = r.isr_valid;
	assign busy = r.busy;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence hi_done_s;
		r.state == eirq_pkg::SEQ_RD_HI && mem_ack;
	endsequence
	sequence lo_done_s;
		r.state == eirq_pkg::SEQ_RD_LO && mem_ack;
	endsequence
	push_first_a: assert property (start && !r.busy |=> push_req && !mem_rd)
		else $error("push not first");
	lo_addr_a: assert property (r.state == eirq_pkg::SEQ_RD_LO |-> mem_addr[4:0] == {r.code, 1'h0})
		else $error("low vector address wrong");
	hi_addr_a: assert property (lo_done_s |=> mem_addr[0] && mem_addr[15:1] == $past(mem_addr[15:1]))
		else $error("high vector address wrong");
	// low byte is held in r.lo from lo_done_s until hi_done_s completes
	isr_build_a: assert property (hi_done_s |=> isr_valid && isr_addr == {$past(mem_rdata), $past(r.lo)})
		else $error("service address not assembled low then high");
endmodule
`default_nettype wire

// [tb/eirq_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// stack and vector memory beside the fetch sequencer
module eirq_mem_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] lat,
	input wire logic push_req,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic push_ack,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	output logic [15:0] log_lo,
	output logic [15:0] log_hi,
	output logic order_err
);
	logic [1:0] wait_cnt;
	logic pushed;
	logic second;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			push_ack <= 1'b0;
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
			log_lo <= 16'h0000;
			log_hi <= 16'h0000;
			order_err <= 1'b0;
			wait_cnt <= 2'h0;
			pushed <= 1'b0;
			second <= 1'b0;
		end else begin
			push_ack <= 1'b0;
			mem_ack <= 1'b0;
			// data is gone once the ack cycle is over, so a late sample sees garbage
			mem_rdata <= ~mem_rdata;
			if (push_req && !push_ack) begin
				wait_cnt <= wait_cnt + 2'h1;
				if (wait_cnt == lat) begin
					push_ack <= 1'b1;
					pushed <= 1'b1;
					wait_cnt <= 2'h0;
				end
			end else if (mem_rd && !mem_ack) begin
				if (!pushed) order_err <= 1'b1;
				wait_cnt <= wait_cnt + 2'h1;
				if (wait_cnt == lat) begin
					mem_ack <= 1'b1;
					mem_rdata <= mem_addr[7:0] ^ 8'hA5;
					wait_cnt <= 2'h0;
					second <= !second;
					if (second) begin
						log_hi <= mem_addr;
						pushed <= 1'b0;
					end else begin
						log_lo <= mem_addr;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_ext_irq_edge_capture_vector.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ext_irq_edge_capture_vector;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0] htrans, lat;
	logic [2:0] hsize;
	logic ext_request_a, ext_request_b, carrier_detect_pin, global_irq_enable_flag;
	logic sample_point, accept_inhibit, instr_done, onchip_req, push_ack, mem_ack;
	logic [3:0] onchip_code;
	logic [7:0] mem_rdata, mode;
	logic drive_reduced, carrier_detect_out, async_clock_out, push_req, mem_rd;
	logic isr_valid, order_err;
	logic [15:0] mem_addr, isr_addr, log_lo, log_hi;
	int n_errors = 0;
	int n_tests = 0;

	eirq_top i_eirq_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .ext_request_a, .ext_request_b,
		.carrier_detect_pin, .global_irq_enable_flag, .sample_point, .accept_inhibit,
		.instr_done, .onchip_req, .onchip_code, .push_ack, .mem_ack, .mem_rdata,
		.drive_reduced, .carrier_detect_out, .async_clock_out, .push_req, .mem_rd,
		.mem_addr, .isr_addr, .isr_valid);
	eirq_mem_model i_eirq_mem_model (.hclk, .hresetn, .lat, .push_req, .mem_rd, .mem_addr,
		.push_ack, .mem_ack, .mem_rdata, .log_lo, .log_hi, .order_err);

	// ==========================================
	// checking and bus access
	task automatic print_verdict;
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) n_errors++;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= 32'(a);
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk(32'(hresp), 32'h0000_0000, "bus response");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		bus(1'b0, a, 32'h0000_0000, x);
	endtask

	// ==========================================
	// pins and instruction stream
	task automatic set_pin(input int p, input logic lvl);
		if (p == 0) ext_request_a <= lvl;
		else ext_request_b <= lvl;
		// covers synchroniser plus latch delay
		repeat (8) @(posedge hclk);
	endtask
	task automatic look(input int p, input logic lvl, input logic act);
		logic [31:0] x;
		rd(8'h00, x);
		chk(32'(x[2 + p]), 32'(lvl), "pin level");
		rd(8'h10, x);
		chk(32'(x[p]), 32'(act), "request");
	endtask
	task automatic instr(input logic inh, input logic late);
		sample_point <= 1'b1;
		accept_inhibit <= inh;
		@(posedge hclk);
		sample_point <= 1'b0;
		accept_inhibit <= 1'b0;
		onchip_req <= late | onchip_req;
		@(posedge hclk);
		instr_done <= 1'b1;
		@(posedge hclk);
		instr_done <= 1'b0;
	endtask
	task automatic fetch(input logic take, input logic [15:0] lo);
		logic seen;
		logic pushed;
		seen = 1'b0;
		pushed = 1'b0;
		repeat (40) begin
			@(posedge hclk);
			if (push_req === 1'b1) pushed = 1'b1;
			if (isr_valid === 1'b1 && !seen) begin
				seen = 1'b1;
				chk(32'(isr_addr), {16'h0000, lo[7:0] ^ 8'hA4, lo[7:0] ^ 8'hA5}, "isr");
				chk(32'(log_lo), 32'(lo), "first read");
				chk(32'(log_hi), 32'(lo | 16'h0001), "second read");
			end
		end
		chk(32'(seen), 32'(take), "fetch taken");
		chk(32'(pushed), 32'(take), "return push");
		chk(32'(order_err), 32'h0000_0000, "push order");
	endtask

	// ==========================================
	// clock, watchdog, tests
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (8000) @(posedge hclk);
		n_errors++;
		print_verdict();
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, lat, hresetn} = '0;
		hsize = 3'h2;
		{ext_request_a, ext_request_b, carrier_detect_pin} = 3'b111;
		{global_irq_enable_flag, sample_point, accept_inhibit, instr_done, onchip_req} = '0;
		onchip_code = 4'h5;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'({drive_reduced, carrier_detect_out, async_clock_out, push_req, mem_rd,
			isr_valid, hreadyout}), 32'h0000_0031, "reset outputs");
		rd(8'h00, v);
		chk(v, 32'h0000_000C, "edge reset");
		rd(8'h04, v);
		chk(v, 32'h0000_0000, "vector low reset");
		rd(8'h10, v);
		chk(v, 32'h0000_0000, "status reset");
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, v);
		chk(v, 32'h0000_0000, "unmapped");
		wr(8'h00, 32'hFFFF_FF03);
		rd(8'h00, v);
		chk(v, 32'h0000_000F, "edge readback");
		carrier_detect_pin <= 1'b0;
		repeat (8) @(posedge hclk);
		chk(32'({drive_reduced, carrier_detect_out, async_clock_out}), 32'h0000_0005, "det");
		wr(8'h00, 32'h0000_0000);
		repeat (2) @(posedge hclk);
		chk(32'({drive_reduced, carrier_detect_out, async_clock_out}), 32'h0000_0000, "clk");
		carrier_detect_pin <= 1'b1;
		// every mode on both pins, changed on the fly between runs
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 4; m++) begin
				mode = 8'(m << (4 + 2 * p));
				wr(8'h00, 32'(mode | 8'h0C));
				set_pin(p, 1'b0);
				look(p, 1'b0, m != 3);
				set_pin(p, 1'b1);
				look(p, 1'b1, m >= 2);
				wr(8'h00, 32'(mode));
				look(p, 1'b1, m >= 2);
				wr(8'h00, 32'(mode | 8'h0C));
				look(p, 1'b1, 1'b0);
			end
		end
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04, v);
		chk(v, 32'h0000_00E0, "vector low");
		wr(8'h0C, 32'h0000_005A);
		wr(8'h08, 32'h0000_0004);
		global_irq_enable_flag <= 1'b1;
		set_pin(0, 1'b0);
		instr(1'b0, 1'b0);
		fetch(1'b0, 16'h0000);
		wr(8'h08, 32'h0000_0006);
		global_irq_enable_flag <= 1'b0;
		instr(1'b0, 1'b0);
		fetch(1'b0, 16'h0000);
		global_irq_enable_flag <= 1'b1;
		instr(1'b1, 1'b0);
		fetch(1'b0, 16'h0000);
		instr(1'b0, 1'b0);
		fetch(1'b1, 16'h5AE0);
		set_pin(0, 1'b1);
		wr(8'h00, 32'h0000_008C);
		set_pin(1, 1'b0);
		lat <= 2'h3;
		instr(1'b0, 1'b0);
		fetch(1'b1, 16'h5AE2);
		set_pin(1, 1'b1);
		wr(8'h00, 32'h0000_000C);
		instr(1'b0, 1'b1);
		fetch(1'b0, 16'h0000);
		lat <= 2'h1;
		instr(1'b0, 1'b0);
		fetch(1'b1, 16'h5AEA);
		print_verdict();
	end
endmodule
`default_nettype wire
